// >>> include/oag_params.svh
// Constants of the operand address generator
// Functional notes
// - Immediate instructions are two bytes: opcode/register, then data or mask.
// - Relative displacement is byte-two bits 6..0, signed, -64 to +63.
// - Relative address is the address after the instruction plus displacement.
// - Byte-two bit 7 set on relative instructions starts an indirect fetch.
// - Page-zero branches are relative to location zero of page zero.
// - Absolute non-branch: three bytes, register bits 1..0, 13-bit in-page address.
// - Index control 00 none, 01 pre-increment, 10 pre-decrement, 11 indexed.
// - Index control 00: named register, direct address, optional indirection.
// - Index control 11: field names index, operand is r0, address plus index.
// - Indexed and indirect: fetch indirect address first, then add the index.
// - Index control 01/10 bumps the index register before forming the address.
// - Absolute branches take bits 6..5 as page bits and load the page.
// - Indirection adds two machine cycles, six clock periods.
// - Indirect address is two bytes, right-justified 15 bits, top bit ignored.
// - Only one level of indirection per instruction.
// - Halt and status-clear operations decode the whole first byte.
// - Load-to-r0 copies register into r0, source kept, two cycles.
// - Opcode 00 is undefined; r0-to-r0 load is opcode 60.
// - Immediate load puts byte two into the register in two cycles.
// - Relative load reads its address into the register, three cycles.
// - Absolute load reads into register, or r0 when indexed, four cycles.
// - One-byte register operations use r0 plus a register of the active bank.
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// Widths
`define OAG_ADDR_W      15
`define OAG_PAGE_W      13
// Machine cycle of three clock periods
`define OAG_LAST_PHASE  2'h2
// Opcode groups, bits 7..2
`define OAG_GRP_LD_R0   6'h00
`define OAG_GRP_LD_IMM  6'h01
`define OAG_GRP_LD_REL  6'h02
`define OAG_GRP_LD_ABS  6'h03
`define OAG_GRP_BRA     6'h07
// Whole-byte opcodes
`define OAG_OP_UNDEF    8'h00
`define OAG_OP_HALT     8'h40
`define OAG_OP_LOADR0   8'h60
`define OAG_OP_CLR_UP   8'h74
`define OAG_OP_CLR_LO   8'h75
`define OAG_OP_ZERO_BR  8'h9b
// Field positions
`define OAG_IND_BIT     7
`define OAG_PSL_RS      4
`define OAG_BRA_ALWAYS  2'h3
// Condition code values
`define OAG_CC_POS      2'h1
`define OAG_CC_ZERO     2'h0
`define OAG_CC_NEG      2'h2
// Reset values
`define OAG_PSL_RST     8'h00
`define OAG_PSU_RST     8'h00
`define OAG_ADDR_RST    15'h0000

`endif

// >>> include/oag_pkg.sv
// Types of the operand address generator
package oag_pkg;

    typedef enum logic [2:0] {
        OAG_ST_FETCH, OAG_ST_EXEC, OAG_ST_BYTE2, OAG_ST_BYTE3,
        OAG_ST_IND_HI, OAG_ST_IND_LO, OAG_ST_OPERAND, OAG_ST_HALT
    } oag_state_t;

    typedef enum logic [1:0] {
        OAG_IC_NONE, OAG_IC_INC, OAG_IC_DEC, OAG_IC_ONLY
    } oag_ic_t;

    typedef enum logic [3:0] {
        OAG_K_LD_R0, OAG_K_LD_IMM, OAG_K_LD_REL, OAG_K_LD_ABS, OAG_K_BRA,
        OAG_K_ZBR, OAG_K_CLR_UP, OAG_K_CLR_LO, OAG_K_HALT, OAG_K_NOP
    } oag_kind_t;

endpackage

// >>> design/oag_core.sv
// Decoder, address generator and load unit of the 8-bit processor
`include "oag_params.svh"

module oag_core (
    input  wire logic                    clock_in,
    input  wire logic                    rst_b_in,
    input  wire logic [7:0]              mem_rdata_in,
    input  wire logic [2:0]              reg_view_sel_in,
    output logic      [`OAG_ADDR_W-1:0]  mem_addr_out,
    output logic                         mem_rd_out,
    output logic                         instr_done_out,
    output logic                         halted_out,
    output logic      [1:0]              condition_code_out,
    output logic      [7:0]              psl_out,
    output logic      [7:0]              psu_out,
    output logic      [7:0]              reg_view_out
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Whole-byte opcodes first, then opcode groups
    function automatic oag_pkg::oag_kind_t decode_kind(input logic [7:0] op);
        oag_pkg::oag_kind_t k;
        k = oag_pkg::OAG_K_NOP;
        if (op == `OAG_OP_HALT)
            k = oag_pkg::OAG_K_HALT;
        else if (op == `OAG_OP_CLR_UP)
            k = oag_pkg::OAG_K_CLR_UP;
        else if (op == `OAG_OP_CLR_LO)
            k = oag_pkg::OAG_K_CLR_LO;
        else if (op == `OAG_OP_ZERO_BR)
            k = oag_pkg::OAG_K_ZBR;
        else if (op == `OAG_OP_LOADR0)
            k = oag_pkg::OAG_K_LD_R0;
        else if (op == `OAG_OP_UNDEF)
            k = oag_pkg::OAG_K_NOP;
        else if (op[7:2] == `OAG_GRP_LD_R0)
            k = oag_pkg::OAG_K_LD_R0;
        else if (op[7:2] == `OAG_GRP_LD_IMM)
            k = oag_pkg::OAG_K_LD_IMM;
        else if (op[7:2] == `OAG_GRP_LD_REL)
            k = oag_pkg::OAG_K_LD_REL;
        else if (op[7:2] == `OAG_GRP_LD_ABS)
            k = oag_pkg::OAG_K_LD_ABS;
        else if (op[7:2] == `OAG_GRP_BRA)
            k = oag_pkg::OAG_K_BRA;
        return k;
    endfunction

    // Register field to file index: r0 shared, r1..r3 banked
    function automatic logic [2:0] reg_idx(input logic [1:0] r, input logic rs);
        logic [2:0] i;
        i = {1'b0, r};
        if (r != 2'h0 && rs)
            i = 3'(r + 2'h0) + 3'h3;
        return i;
    endfunction

    // In-page increment, page bits kept
    function automatic logic [`OAG_ADDR_W-1:0] inc_in_page(
        input logic [`OAG_ADDR_W-1:0] a);
        return {a[14:13], a[12:0] + 13'h0001};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0]               phase_q;
    oag_pkg::oag_state_t      state_q, state_d;
    oag_pkg::oag_kind_t       kind_q, kind_d;
    logic [7:0]               op_q;
    logic [7:0]               b2_q;
    logic [`OAG_ADDR_W-1:0]   iar_q, iar_d;
    logic [`OAG_ADDR_W-1:0]   ea_q, ea_d;
    logic [`OAG_ADDR_W-1:0]   mem_addr_q, addr_d;
    logic                     mem_rd_q, rd_d;
    logic [6:0]               ind_hi_q;
    logic [7:0]               idx_val_q, idx_val_d;
    logic [7:0]               psl_q, psl_d;
    logic [7:0]               psu_q, psu_d;
    logic [7:0]               regs [7];
    logic                     wr_en, wr_cc;
    logic [2:0]               wr_sel;
    logic [7:0]               wr_val;
    logic                     done_d;
    logic                     instr_done_q;
    logic [7:0]               reg_view_q;
    logic                     halted_q;

    logic                     cyc_end;
    logic                     rs;
    oag_pkg::oag_ic_t         ic_b2;
    logic                     indexed;
    logic [`OAG_ADDR_W-1:0]   iar_inc;
    logic [12:0]              disp13;
    logic [12:0]              abs_low;
    logic [`OAG_ADDR_W-1:0]   ind_addr;
    logic                     bra_taken;

    assign cyc_end   = (phase_q == `OAG_LAST_PHASE);
    assign rs        = psl_q[`OAG_PSL_RS];
    assign ic_b2     = oag_pkg::oag_ic_t'(b2_q[6:5]);
    assign indexed   = (kind_q == oag_pkg::OAG_K_LD_ABS) && (ic_b2 != oag_pkg::OAG_IC_NONE);
    assign iar_inc   = inc_in_page(iar_q);
    assign disp13    = {{6{mem_rdata_in[6]}}, mem_rdata_in[6:0]};
    assign abs_low   = {b2_q[4:0], mem_rdata_in};
    assign ind_addr  = {ind_hi_q, mem_rdata_in} +
                       (indexed ? {7'h00, idx_val_q} : 15'h0000);
    assign bra_taken = (op_q[1:0] == `OAG_BRA_ALWAYS) || (op_q[1:0] == psl_q[7:6]);

    // ------------------------------------------------------------
    // Machine-cycle sequencing
    // ------------------------------------------------------------

    // Work done at the end of each three-clock machine cycle
    always_comb begin
        state_d   = state_q;
        kind_d    = kind_q;
        iar_d     = iar_q;
        ea_d      = ea_q;
        addr_d    = mem_addr_q;
        rd_d      = mem_rd_q;
        idx_val_d = idx_val_q;
        psl_d     = psl_q;
        psu_d     = psu_q;
        wr_en     = 1'b0;
        wr_cc     = 1'b0;
        wr_sel    = 3'h0;
        wr_val    = 8'h00;
        done_d    = 1'b0;
        unique case (state_q)
            oag_pkg::OAG_ST_FETCH: begin
                kind_d = decode_kind(mem_rdata_in);
                iar_d  = iar_inc;
                if (decode_kind(mem_rdata_in) == oag_pkg::OAG_K_HALT) begin
                    state_d = oag_pkg::OAG_ST_HALT;
                    rd_d    = 1'b0;
                end else if (decode_kind(mem_rdata_in) == oag_pkg::OAG_K_LD_R0 ||
                             decode_kind(mem_rdata_in) == oag_pkg::OAG_K_NOP) begin
                    state_d = oag_pkg::OAG_ST_EXEC;
                    rd_d    = 1'b0;
                end else begin
                    state_d = oag_pkg::OAG_ST_BYTE2;
                    addr_d  = iar_inc;
                    rd_d    = 1'b1;
                end
            end
            oag_pkg::OAG_ST_EXEC: begin
                // Copy into r0, source untouched
                if (kind_q == oag_pkg::OAG_K_LD_R0) begin
                    wr_en  = 1'b1;
                    wr_cc  = 1'b1;
                    wr_sel = 3'h0;
                    wr_val = regs[reg_idx(op_q[1:0], rs)];
                end
                state_d = oag_pkg::OAG_ST_FETCH;
                addr_d  = iar_q;
                rd_d    = 1'b1;
                done_d  = 1'b1;
            end
            oag_pkg::OAG_ST_BYTE2: begin
                iar_d   = iar_inc;
                state_d = oag_pkg::OAG_ST_FETCH;
                addr_d  = iar_inc;
                rd_d    = 1'b1;
                unique case (kind_q)
                    oag_pkg::OAG_K_LD_IMM: begin
                        wr_en  = 1'b1;
                        wr_cc  = 1'b1;
                        wr_sel = reg_idx(op_q[1:0], rs);
                        wr_val = mem_rdata_in;
                        done_d = 1'b1;
                    end
                    oag_pkg::OAG_K_CLR_UP: begin
                        psu_d  = psu_q & ~mem_rdata_in;
                        done_d = 1'b1;
                    end
                    oag_pkg::OAG_K_CLR_LO: begin
                        psl_d  = psl_q & ~mem_rdata_in;
                        done_d = 1'b1;
                    end
                    oag_pkg::OAG_K_LD_REL: begin
                        // Base is the byte after the instruction
                        ea_d    = {iar_inc[14:13], iar_inc[12:0] + disp13};
                        addr_d  = {iar_inc[14:13], iar_inc[12:0] + disp13};
                        state_d = mem_rdata_in[`OAG_IND_BIT] ?
                                  oag_pkg::OAG_ST_IND_HI : oag_pkg::OAG_ST_OPERAND;
                    end
                    oag_pkg::OAG_K_ZBR: begin
                        // Wraps to the top 64 bytes of page zero when negative
                        ea_d   = {2'b00, disp13};
                        addr_d = {2'b00, disp13};
                        if (mem_rdata_in[`OAG_IND_BIT]) begin
                            state_d = oag_pkg::OAG_ST_IND_HI;
                        end else begin
                            iar_d  = {2'b00, disp13};
                            done_d = 1'b1;
                        end
                    end
                    oag_pkg::OAG_K_LD_ABS, oag_pkg::OAG_K_BRA: begin
                        state_d = oag_pkg::OAG_ST_BYTE3;
                        if (kind_q == oag_pkg::OAG_K_LD_ABS) begin
                            // Index bumped before any address is formed
                            unique case (oag_pkg::oag_ic_t'(mem_rdata_in[6:5]))
                                oag_pkg::OAG_IC_INC:
                                    idx_val_d = regs[reg_idx(op_q[1:0], rs)] + 8'h01;
                                oag_pkg::OAG_IC_DEC:
                                    idx_val_d = regs[reg_idx(op_q[1:0], rs)] - 8'h01;
                                default:
                                    idx_val_d = regs[reg_idx(op_q[1:0], rs)];
                            endcase
                            if (mem_rdata_in[6] ^ mem_rdata_in[5]) begin
                                wr_en  = 1'b1;
                                wr_sel = reg_idx(op_q[1:0], rs);
                                wr_val = idx_val_d;
                            end
                        end
                    end
                    default: begin
                        done_d = 1'b1;
                    end
                endcase
            end
            oag_pkg::OAG_ST_BYTE3: begin
                iar_d   = iar_inc;
                addr_d  = iar_inc;
                rd_d    = 1'b1;
                state_d = oag_pkg::OAG_ST_FETCH;
                if (kind_q == oag_pkg::OAG_K_BRA) begin
                    if (bra_taken) begin
                        // Page bits come from byte two
                        ea_d   = {b2_q[6:5], abs_low};
                        addr_d = {b2_q[6:5], abs_low};
                        if (b2_q[`OAG_IND_BIT]) begin
                            state_d = oag_pkg::OAG_ST_IND_HI;
                        end else begin
                            iar_d  = {b2_q[6:5], abs_low};
                            done_d = 1'b1;
                        end
                    end else begin
                        done_d = 1'b1;
                    end
                end else begin
                    // Direct or indexed address inside the current page
                    if (b2_q[`OAG_IND_BIT] || !indexed)
                        ea_d = {iar_q[14:13], abs_low};
                    else
                        ea_d = {iar_q[14:13], abs_low + {5'h00, idx_val_q}};
                    addr_d  = ea_d;
                    state_d = b2_q[`OAG_IND_BIT] ?
                              oag_pkg::OAG_ST_IND_HI : oag_pkg::OAG_ST_OPERAND;
                end
            end
            oag_pkg::OAG_ST_IND_HI: begin
                // Second of the two added cycles follows
                addr_d  = inc_in_page(ea_q);
                state_d = oag_pkg::OAG_ST_IND_LO;
            end
            oag_pkg::OAG_ST_IND_LO: begin
                // Fetched address is final, no second level
                ea_d   = ind_addr;
                addr_d = ind_addr;
                if (kind_q == oag_pkg::OAG_K_LD_REL || kind_q == oag_pkg::OAG_K_LD_ABS) begin
                    state_d = oag_pkg::OAG_ST_OPERAND;
                end else begin
                    state_d = oag_pkg::OAG_ST_FETCH;
                    iar_d   = ind_addr;
                    done_d  = 1'b1;
                end
            end
            oag_pkg::OAG_ST_OPERAND: begin
                wr_en   = 1'b1;
                wr_cc   = 1'b1;
                wr_sel  = indexed ? 3'h0 : reg_idx(op_q[1:0], rs);
                wr_val  = mem_rdata_in;
                state_d = oag_pkg::OAG_ST_FETCH;
                addr_d  = iar_q;
                done_d  = 1'b1;
            end
            oag_pkg::OAG_ST_HALT: begin
                rd_d = 1'b0;
            end
        endcase
        // Load sets the condition code from the byte written
        if (wr_cc) begin
            if (wr_val == 8'h00)
                psl_d[7:6] = `OAG_CC_ZERO;
            else if (wr_val[7])
                psl_d[7:6] = `OAG_CC_NEG;
            else
                psl_d[7:6] = `OAG_CC_POS;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Phase counter: three clocks per machine cycle
    always_ff @(posedge clock_in) begin
        if (!rst_b_in)
            phase_q <= 2'h0;
        else if (cyc_end)
            phase_q <= 2'h0;
        else
            phase_q <= phase_q + 2'h1;
    end

    // Sequencer and instruction capture
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_q <= oag_pkg::OAG_ST_FETCH;
            kind_q  <= oag_pkg::OAG_K_NOP;
            op_q    <= 8'h00;
            b2_q    <= 8'h00;
        end else if (cyc_end) begin
            state_q <= state_d;
            kind_q  <= kind_d;
            if (state_q == oag_pkg::OAG_ST_FETCH)
                op_q <= mem_rdata_in;
            if (state_q == oag_pkg::OAG_ST_BYTE2)
                b2_q <= mem_rdata_in;
        end
    end

    // Address path: program counter, operand address, bus address
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            iar_q      <= `OAG_ADDR_RST;
            ea_q       <= `OAG_ADDR_RST;
            mem_addr_q <= `OAG_ADDR_RST;
            mem_rd_q   <= 1'b1;
            ind_hi_q   <= 7'h00;
            idx_val_q  <= 8'h00;
        end else if (cyc_end) begin
            iar_q      <= iar_d;
            ea_q       <= ea_d;
            mem_addr_q <= addr_d;
            mem_rd_q   <= rd_d;
            idx_val_q  <= idx_val_d;
            if (state_q == oag_pkg::OAG_ST_IND_HI)
                ind_hi_q <= mem_rdata_in[6:0];
        end
    end

    // Register file, one write per machine cycle
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 7; i++)
                regs[i] <= 8'h00;
        end else if (cyc_end && wr_en) begin
            regs[wr_sel] <= wr_val;
        end
    end

    // Program status bytes
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            psl_q <= `OAG_PSL_RST;
            psu_q <= `OAG_PSU_RST;
        end else if (cyc_end) begin
            psl_q <= psl_d;
            psu_q <= psu_d;
        end
    end

    // Observation outputs
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            instr_done_q <= 1'b0;
            reg_view_q   <= 8'h00;
            halted_q     <= 1'b0;
        end else begin
            instr_done_q <= cyc_end && done_d;
            halted_q     <= ((cyc_end ? state_d : state_q) == oag_pkg::OAG_ST_HALT);
            reg_view_q   <= (reg_view_sel_in < 3'h7) ? regs[reg_view_sel_in] : 8'h00;
        end
    end

    assign mem_addr_out       = mem_addr_q;
    assign mem_rd_out         = mem_rd_q;
    assign instr_done_out     = instr_done_q;
    assign halted_out         = halted_q;
    assign condition_code_out = psl_q[7:6];
    assign psl_out            = psl_q;
    assign psu_out            = psu_q;
    assign reg_view_out       = reg_view_q;

endmodule

// >>> verification/oag_mem_model.sv
// Behavioural program and data memory facing the core
module oag_mem_model (
    input  wire logic        clock_in,
    input  wire logic [14:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        slow_in,
    output logic      [7:0]  data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:32767];
    logic [7:0]  last_q;
    logic [14:0] addr_q;
    // Remember last byte and address
    always_ff @(posedge clock_in) begin
        last_q <= data_out;
        addr_q <= addr_in;
    end
    // Idle or slow first clock shows a changing pattern
    always_comb begin
        if (!rd_in || (slow_in && addr_in != addr_q)) begin
            data_out = ~last_q;
        end else begin
            data_out = mem[addr_in];
        end
    end
endmodule

// >>> verification/oag_core_asserts.sv
// Port checker of the operand address generator
`include "oag_params.svh"
module oag_core_asserts (
    input wire logic                   clock_in,
    input wire logic                   rst_b_in,
    input wire logic [2:0]             reg_view_sel_in,
    input wire logic [`OAG_ADDR_W-1:0] mem_addr_out,
    input wire logic                   mem_rd_out,
    input wire logic                   instr_done_out,
    input wire logic                   halted_out,
    input wire logic [1:0]             condition_code_out,
    input wire logic [7:0]             psl_out,
    input wire logic [7:0]             reg_view_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    logic [1:0] ph_q;
    // Machine cycle phase follower
    always_ff @(posedge clock_in) begin
        if (!rst_b_in || ph_q == `OAG_LAST_PHASE) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end
    sequence s_quiet;
        !instr_done_out [*5];
    endsequence
    a_addr_holds: assert property (
        ph_q != 2'h0 |-> $stable(mem_addr_out) && $stable(mem_rd_out))
        else $error("address moved inside a machine cycle");
    a_done_spacing: assert property (instr_done_out |=> s_quiet)
        else $error("instructions closer than two cycles");
    a_halt_no_read: assert property (halted_out && $past(halted_out, 3) |-> !mem_rd_out)
        else $error("read while halted");
    a_halt_sticky: assert property (halted_out |=> halted_out)
        else $error("halt left without reset");
    a_cc_legal: assert property (condition_code_out != 2'h3)
        else $error("illegal condition code");
    a_cc_in_psl: assert property (condition_code_out == psl_out[7:6])
        else $error("condition code not in status");
    a_first_fetch: assert property (
        $rose(rst_b_in) |-> mem_addr_out == 15'h0000 && mem_rd_out)
        else $error("first fetch not at zero");
    a_view_blank: assert property (reg_view_sel_in == 3'h7 |=> reg_view_out == 8'h00)
        else $error("unused view slot not zero");
endmodule
bind oag_core oag_core_asserts u_chk (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .reg_view_sel_in(reg_view_sel_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .instr_done_out(instr_done_out), .halted_out(halted_out),
    .condition_code_out(condition_code_out), .psl_out(psl_out), .reg_view_out(reg_view_out));

// >>> verification/operand_address_generator_tb.sv
// Self-checking bench of the operand address generator
module operand_address_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in, rst_b_in, slow, rd, done, halt;
    logic [2:0]  sel;
    logic [7:0]  rdata, psl, psu, view;
    logic [14:0] addr;
    logic [1:0]  cc;
    int          miscompares, tests_run, cyc;
    int          dq[$];
    // Clock
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    oag_core dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .mem_rdata_in(rdata),
        .reg_view_sel_in(sel), .mem_addr_out(addr), .mem_rd_out(rd), .instr_done_out(done),
        .halted_out(halt), .condition_code_out(cc), .psl_out(psl), .psu_out(psu),
        .reg_view_out(view));
    oag_mem_model u_mem (.clock_in(clock_in), .addr_in(addr), .rd_in(rd), .slow_in(slow),
        .data_out(rdata));
    // Cycle count, completion times and timeout
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (rst_b_in && done === 1'b1) dq.push_back(cyc);
        if (cyc == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic prog(input int a, input logic [7:0] b[$]);
        foreach (b[i]) u_mem.mem[a+i] = b[i];
    endtask
    task automatic run(input string n, input logic s);
        int k;
        for (k = 0; k < 32768; k++) u_mem.mem[k] = 8'h00;
        for (k = 0; k < n.len(); k++) begin end
        slow <= s;
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        dq.delete();
        rst_b_in <= 1'b1;
    endtask
    task automatic wait_halt(input string n);
        int k;
        k = 0;
        while (halt !== 1'b1 && k < 400) begin
            @(posedge clock_in);
            k++;
        end
        chk({7'h0, halt}, 8'h01, {n, " halt"});
        $display("test %s finished", n);
    endtask
    task automatic reg_is(input logic [2:0] s, input logic [7:0] e);
        sel <= s;
        repeat (2) @(posedge clock_in);
        chk(view, e, "register");
    endtask
    task automatic gap(input int k, input int c);
        chk(8'(dq[k+1] - dq[k]), 8'(3 * c), "instruction length");
    endtask
    task automatic t_load();
        run("load", 1'b0);
        prog(0, '{8'h05, 8'h80, 8'h06, 8'h00, 8'h07, 8'h3f, 8'h00, 8'h01, 8'h60, 8'h75, 8'h40,
            8'h40});
        wait_halt("load");
        reg_is(3'h1, 8'h80);
        reg_is(3'h2, 8'h00);
        reg_is(3'h0, 8'h80);
        reg_is(3'h7, 8'h00);
        chk(psl, 8'h80, "status mask");
        chk(psu, 8'h00, "upper status");
        gap(0, 2);
        gap(2, 2);
        gap(3, 2);
    endtask
    task automatic t_rel();
        run("relative", 1'b0);
        prog(0, '{8'h05, 8'h07, 8'h09, 8'h7e, 8'h0a, 8'h9c, 8'h40});
        prog('h22, '{8'h81, 8'h23});
        prog('h123, '{8'hf0});
        wait_halt("relative");
        reg_is(3'h1, 8'h09);
        reg_is(3'h2, 8'hf0);
        chk({6'h0, cc}, 8'h02, "cc negative");
        gap(0, 3);
        gap(1, 5);
    endtask
    task automatic t_abs();
        run("absolute", 1'b0);
        prog(0, '{8'h05, 8'h05, 8'h07, 8'h10, 8'h0e, 8'h00, 8'h30, 8'h0d, 8'h20, 8'h30, 8'h0f,
            8'h40, 8'h30, 8'h0d, 8'he0, 8'h40, 8'h40});
        prog('h30, '{8'h8c});
        prog('h40, '{8'h00, 8'h50});
        prog('h56, '{8'h56});
        wait_halt("absolute");
        reg_is(3'h2, 8'h8c);
        reg_is(3'h1, 8'h06);
        reg_is(3'h3, 8'h0f);
        reg_is(3'h0, 8'h56);
        chk({6'h0, cc}, 8'h01, "cc positive");
        gap(1, 4);
        gap(3, 4);
        gap(4, 6);
    endtask
    task automatic t_branch();
        run("branch", 1'b1);
        prog(0, '{8'h9b, 8'h7a});
        prog('h1ffa, '{8'h06, 8'h22, 8'h1f, 8'h20, 8'h10});
        prog('h2010, '{8'h05, 8'h11, 8'h40});
        wait_halt("branch");
        reg_is(3'h2, 8'h22);
        reg_is(3'h1, 8'h11);
        gap(1, 3);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_b_in = 1'b0;
        sel = 3'h0;
        slow = 1'b0;
        cyc = 0;
        t_load();
        t_rel();
        t_abs();
        t_branch();
        end_of_test();
    end
endmodule
